/* ppf_pkg.sv */
// Package for the protection frame: register map, field positions, sizes and reset values
package ppf_pkg;
	localparam int NUM_ELEM = 8;
	localparam int NUM_SRC = 16;
	localparam int SEL_W = 5;
	localparam logic [SEL_W-1:0] SEL_NONE = 5'h1F;
	// Register byte addresses
	localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h00;
	localparam logic [7:0] ADDR_GLOBAL_SEL = 8'h04;
	localparam logic [7:0] ADDR_ELEM_ENABLE = 8'h08;
	localparam logic [7:0] ADDR_ELEM_EXT_PERMIT = 8'h0C;
	localparam logic [7:0] ADDR_ELEM_TRIP_BLOCK = 8'h10;
	localparam logic [7:0] ADDR_ELEM_TRIP_PERMIT = 8'h14;
	localparam logic [7:0] ADDR_ELEM_CLASS = 8'h18;
	localparam logic [7:0] ADDR_CB_ASSIGN = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_FAULT_CNT = 8'h24;
	localparam logic [7:0] ADDR_ELEM_SEL_BASE = 8'h40;
	localparam logic [7:0] ADDR_ELEM_SEL_END = 8'h5C;
	// Global control fields
	localparam int GC_ENABLE = 0;
	localparam int GC_EXT_PERMIT = 1;
	localparam int GC_TRIP_SUPPRESS = 2;
	localparam int GC_TRIP_PERMIT = 3;
	localparam int GC_COUNTER_CLEAR = 4;
	localparam logic [4:0] GC_RESET = 5'h01;
	// Global source selects
	localparam int GS_SRC_A = 0;
	localparam int GS_SRC_B = 8;
	localparam int GS_TRIP_SRC = 16;
	// Element source selects
	localparam int ES_BLOCK = 0;
	localparam int ES_TRIP = 8;
	// Element class fields
	localparam int EC_SUPERV = 0;
	localparam int EC_FUND = 8;
	localparam int EC_CURRENT = 16;
	localparam logic [NUM_ELEM-1:0] ELEM_RESET_ON = 8'hFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* ppf_frame.sv */
// Protection master frame: blocking, trip suppression, alarm and trip collection
//
// Functional notes
// - Global disable suppresses every element output.
// - Per-element enable gates its alarms and trips.
// - Per-stage trip block keeps alarm, kills trip.
// - Global external block when source A or B.
// - Element blocked when permit and source active.
// - Stage trip suppressed when permit and source.
// - Global trip suppress kills all trips.
// - Global external trip suppress via assigned input.
// - Off-frequency blocks fundamental elements, RMS stays.
// - Current elements accept reverse-interlock block.
// - Elements keep own alarm and trip outputs.
// - Phase and earth alarm are OR collections.
// - Phase and earth trip are OR collections.
// - General alarm and trip are ORs.
// - Supervision alarms excluded; breaker failure included.
// - Only assigned trips reach breaker command.
// - Clear command resets both fault counters.
// - Reset defaults: enable on, others off.
// - Export active, blocked, trip blocked status.
// - Expose global block input states.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module ppf_frame
	import ppf_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	input wire logic [NUM_SRC-1:0] BLOCK_SRC_I,
	input wire logic FREQ_OK_I,
	input wire logic [NUM_ELEM-1:0] REV_INTERLOCK_I,
	input wire logic [NUM_ELEM-1:0] ELEM_ALARM_I,
	input wire logic [NUM_ELEM-1:0] ELEM_TRIP_I,
	input wire logic [NUM_ELEM*4-1:0] ELEM_PHASE_I,
	input wire logic FAULT_EVENT_I,
	input wire logic GRID_FAULT_EVENT_I,
	output logic [NUM_ELEM-1:0] ELEM_ALARM_O,
	output logic [NUM_ELEM-1:0] ELEM_TRIP_O,
	output logic [3:0] PHASE_ALARM_O,
	output logic [3:0] PHASE_TRIP_O,
	output logic GENERAL_ALARM_O,
	output logic GENERAL_TRIP_O,
	output logic BREAKER_TRIP_O,
	output logic PROT_ACTIVE_O,
	output logic EXT_BLOCKED_O,
	output logic TRIP_BLOCKED_O,
	output logic TRIP_EXT_BLOCKED_O,
	output logic [2:0] GLOBAL_INPUT_STATE_O,
	output logic FAULT_CLEAR_O,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// Settings
	logic [4:0] gctrl_q;
	logic [23:0] gsel_q;
	logic [NUM_ELEM-1:0] en_q, ext_permit_q, trip_block_q, trip_permit_q, cb_assign_q;
	logic [NUM_ELEM-1:0] superv_q, fund_q, current_q;
	logic [15:0] esel_q [NUM_ELEM];
	logic [15:0] fault_cnt_q, grid_cnt_q;

	// Two-stage synchronisers for the block source, frequency and reverse-interlock inputs
	// Frequency flag resets to in range, so nothing is blocked as reset ends
	logic [NUM_SRC-1:0] src_m_q, src_q;
	logic freq_m_q, freq_q;
	logic [NUM_ELEM-1:0] ril_m_q, ril_q;
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			src_m_q <= '0;
			src_q <= '0;
			freq_m_q <= 1'b1;
			freq_q <= 1'b1;
			ril_m_q <= '0;
			ril_q <= '0;
		end else begin
			src_m_q <= BLOCK_SRC_I;
			src_q <= src_m_q;
			freq_m_q <= FREQ_OK_I;
			freq_q <= freq_m_q;
			ril_m_q <= REV_INTERLOCK_I;
			ril_q <= ril_m_q;
		end
	end

	// Selected source; an unassigned or out-of-range select reads false
	function automatic logic pick(input logic [NUM_SRC-1:0] s, input logic [7:0] sel);
		logic r;
		r = 1'b0;
		if (sel < 8'(NUM_SRC))
			r = s[sel[3:0]];
		return r;
	endfunction

	// Gating of each element by global, element and stage blocks
	logic blk_a, blk_b, blk_t, glob_ext_blk, glob_on, glob_trip_off;
	logic [NUM_ELEM-1:0] elem_live, elem_trip_ok, alarm_g, trip_g;
	logic [3:0] ph_alarm, ph_trip;
	always_comb begin
		blk_a = pick(src_q, gsel_q[GS_SRC_A +: 8]);
		blk_b = pick(src_q, gsel_q[GS_SRC_B +: 8]);
		blk_t = pick(src_q, gsel_q[GS_TRIP_SRC +: 8]);
		glob_ext_blk = gctrl_q[GC_EXT_PERMIT] & (blk_a | blk_b);
		glob_on = gctrl_q[GC_ENABLE] & ~glob_ext_blk;
		glob_trip_off = gctrl_q[GC_TRIP_SUPPRESS]
			| (gctrl_q[GC_TRIP_PERMIT] & blk_t);
		ph_alarm = '0;
		ph_trip = '0;
		for (int i = 0; i < NUM_ELEM; i++) begin
			elem_live[i] = glob_on & en_q[i]
				& ~(ext_permit_q[i] & pick(src_q, esel_q[i][ES_BLOCK +: 8]))
				& ~(fund_q[i] & ~freq_q)
				& ~(current_q[i] & ril_q[i]);
			elem_trip_ok[i] = ~trip_block_q[i]
				& ~(trip_permit_q[i] & pick(src_q, esel_q[i][ES_TRIP +: 8]))
				& ~glob_trip_off;
			alarm_g[i] = elem_live[i] & ELEM_ALARM_I[i];
			trip_g[i] = elem_live[i] & elem_trip_ok[i] & ELEM_TRIP_I[i];
			ph_alarm = ph_alarm | ({4{alarm_g[i]}} & ELEM_PHASE_I[i*4 +: 4]);
			ph_trip = ph_trip | ({4{trip_g[i]}} & ELEM_PHASE_I[i*4 +: 4]);
		end
	end

	// Registered outputs, one cycle after element inputs or settings change
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ELEM_ALARM_O <= '0;
			ELEM_TRIP_O <= '0;
			PHASE_ALARM_O <= '0;
			PHASE_TRIP_O <= '0;
			GENERAL_ALARM_O <= 1'b0;
			GENERAL_TRIP_O <= 1'b0;
			BREAKER_TRIP_O <= 1'b0;
		end else begin
			ELEM_ALARM_O <= alarm_g;
			ELEM_TRIP_O <= trip_g;
			PHASE_ALARM_O <= ph_alarm;
			PHASE_TRIP_O <= ph_trip;
			GENERAL_ALARM_O <= |(alarm_g & ~superv_q);
			GENERAL_TRIP_O <= |trip_g;
			BREAKER_TRIP_O <= |(trip_g & cb_assign_q);
		end
	end

	// Status flags move in the same cycle as the gated outputs
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PROT_ACTIVE_O <= 1'b0;
			EXT_BLOCKED_O <= 1'b0;
			TRIP_BLOCKED_O <= 1'b0;
			TRIP_EXT_BLOCKED_O <= 1'b0;
			GLOBAL_INPUT_STATE_O <= '0;
		end else begin
			PROT_ACTIVE_O <= glob_on;
			EXT_BLOCKED_O <= glob_ext_blk;
			TRIP_BLOCKED_O <= gctrl_q[GC_TRIP_SUPPRESS];
			TRIP_EXT_BLOCKED_O <= gctrl_q[GC_TRIP_PERMIT] & blk_t;
			GLOBAL_INPUT_STATE_O <= {blk_t, blk_b, blk_a};
		end
	end

	// Fault counters; clear command wins over a counting event
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			fault_cnt_q <= '0;
			grid_cnt_q <= '0;
			FAULT_CLEAR_O <= 1'b0;
		end else begin
			FAULT_CLEAR_O <= gctrl_q[GC_COUNTER_CLEAR];
			if (gctrl_q[GC_COUNTER_CLEAR]) begin
				fault_cnt_q <= '0;
				grid_cnt_q <= '0;
			end else begin
				if (FAULT_EVENT_I)
					fault_cnt_q <= fault_cnt_q + 16'h0001;
				if (GRID_FAULT_EVENT_I)
					grid_cnt_q <= grid_cnt_q + 16'h0001;
			end
		end
	end

	// AXI4-Lite write channel: address and data taken in either order
	logic aw_hold_q, w_hold_q;
	logic [7:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic do_wr;
	logic [7:0] wa;
	logic [31:0] wdat;
	logic [3:0] wstb;
	// Either half comes from its holding register once it has been taken
	assign wa = aw_hold_q ? aw_q : S_AXI_AWADDR;
	assign wdat = w_hold_q ? wd_q : S_AXI_WDATA;
	assign wstb = w_hold_q ? ws_q : S_AXI_WSTRB;
	assign do_wr = (aw_hold_q | (S_AXI_AWVALID & S_AXI_AWREADY))
		& (w_hold_q | (S_AXI_WVALID & S_AXI_WREADY));

	// Address or data of a write taken ahead of its other half
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
		end else begin
			if (S_AXI_AWVALID & S_AXI_AWREADY)
				aw_q <= S_AXI_AWADDR;
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				wd_q <= S_AXI_WDATA;
				ws_q <= S_AXI_WSTRB;
			end
		end
	end

	// Which half of a write waits for the other; both drop when the write lands
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
		end else if (do_wr) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
		end else begin
			if (S_AXI_AWVALID & S_AXI_AWREADY)
				aw_hold_q <= 1'b1;
			if (S_AXI_WVALID & S_AXI_WREADY)
				w_hold_q <= 1'b1;
		end
	end

	// Readies stay low while a response waits, so only one write is under way
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			S_AXI_AWREADY <= ~aw_hold_q & ~S_AXI_BVALID & ~(S_AXI_AWVALID & S_AXI_AWREADY);
			S_AXI_WREADY <= ~w_hold_q & ~S_AXI_BVALID & ~(S_AXI_WVALID & S_AXI_WREADY);
			if (do_wr) begin
				S_AXI_AWREADY <= 1'b0;
				S_AXI_WREADY <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok(wa) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID & S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	function automatic logic wr_ok(input logic [7:0] a);
		logic r;
		r = (a[7:2] <= ADDR_CB_ASSIGN[7:2])
			| (a[7:2] >= ADDR_ELEM_SEL_BASE[7:2] && a[7:2] <= ADDR_ELEM_SEL_END[7:2]);
		return r;
	endfunction

	// Readable words: every writable setting plus the two read-only words
	function automatic logic rd_ok(input logic [7:0] a);
		logic r;
		r = wr_ok(a) | (a[7:2] == ADDR_STATUS[7:2]) | (a[7:2] == ADDR_FAULT_CNT[7:2]);
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (st[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	// Setting registers
	// A refused write leaves every setting as it was
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			gctrl_q <= GC_RESET;
			gsel_q <= {3{3'h0, SEL_NONE}};
			en_q <= ELEM_RESET_ON;
			ext_permit_q <= '0;
			trip_block_q <= '0;
			trip_permit_q <= '0;
			cb_assign_q <= '0;
			superv_q <= '0;
			fund_q <= '0;
			current_q <= '0;
			for (int i = 0; i < NUM_ELEM; i++)
				esel_q[i] <= {3'h0, SEL_NONE, 3'h0, SEL_NONE};
		end else if (do_wr) begin
			unique case (wa[7:2])
				ADDR_GLOBAL_CTRL[7:2]: gctrl_q <= 5'(merge(32'(gctrl_q), wdat, wstb));
				ADDR_GLOBAL_SEL[7:2]: gsel_q <= 24'(merge(32'(gsel_q), wdat, wstb));
				ADDR_ELEM_ENABLE[7:2]: if (wstb[0]) en_q <= wdat[7:0];
				ADDR_ELEM_EXT_PERMIT[7:2]: if (wstb[0]) ext_permit_q <= wdat[7:0];
				ADDR_ELEM_TRIP_BLOCK[7:2]: if (wstb[0]) trip_block_q <= wdat[7:0];
				ADDR_ELEM_TRIP_PERMIT[7:2]: if (wstb[0]) trip_permit_q <= wdat[7:0];
				ADDR_ELEM_CLASS[7:2]: begin
					if (wstb[0]) superv_q <= wdat[EC_SUPERV +: 8];
					if (wstb[1]) fund_q <= wdat[EC_FUND +: 8];
					if (wstb[2]) current_q <= wdat[EC_CURRENT +: 8];
				end
				ADDR_CB_ASSIGN[7:2]: if (wstb[0]) cb_assign_q <= wdat[7:0];
				default: begin
					if (wr_ok(wa))
						esel_q[wa[4:2]] <= 16'(merge(32'(esel_q[wa[4:2]]), wdat, wstb));
				end
			endcase
		end
	end

	// AXI4-Lite read channel
	logic [31:0] rd;
	always_comb begin
		rd = '0;
		unique case (S_AXI_ARADDR[7:2])
			ADDR_GLOBAL_CTRL[7:2]: rd = 32'(gctrl_q);
			ADDR_GLOBAL_SEL[7:2]: rd = 32'(gsel_q);
			ADDR_ELEM_ENABLE[7:2]: rd = 32'(en_q);
			ADDR_ELEM_EXT_PERMIT[7:2]: rd = 32'(ext_permit_q);
			ADDR_ELEM_TRIP_BLOCK[7:2]: rd = 32'(trip_block_q);
			ADDR_ELEM_TRIP_PERMIT[7:2]: rd = 32'(trip_permit_q);
			ADDR_ELEM_CLASS[7:2]: rd = {8'h00, current_q, fund_q, superv_q};
			ADDR_CB_ASSIGN[7:2]: rd = 32'(cb_assign_q);
			// General trip is the OR of the element trip bits, so it is left out of the word
			ADDR_STATUS[7:2]: rd = {GENERAL_ALARM_O, PHASE_TRIP_O, PHASE_ALARM_O, ELEM_TRIP_O,
				ELEM_ALARM_O, GLOBAL_INPUT_STATE_O, TRIP_EXT_BLOCKED_O, TRIP_BLOCKED_O,
				EXT_BLOCKED_O, PROT_ACTIVE_O};
			ADDR_FAULT_CNT[7:2]: rd = {grid_cnt_q, fault_cnt_q};
			default: begin
				if (wr_ok(S_AXI_ARADDR))
					rd = 32'(esel_q[S_AXI_ARADDR[4:2]]);
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
			if (S_AXI_ARVALID & S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd;
				S_AXI_RRESP <= rd_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RVALID & S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end
endmodule

/* ppf_frame_monitor.sv */
// Checker of the collected alarm, trip and status relations of the protection frame
`timescale 1ns/1ps
module ppf_frame_monitor
	import ppf_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	input wire logic [NUM_ELEM-1:0] ELEM_ALARM_I,
	input wire logic [NUM_ELEM-1:0] ELEM_TRIP_I,
	input wire logic [NUM_ELEM*4-1:0] ELEM_PHASE_I,
	input wire logic [NUM_ELEM-1:0] ELEM_ALARM_O,
	input wire logic [NUM_ELEM-1:0] ELEM_TRIP_O,
	input wire logic [3:0] PHASE_ALARM_O,
	input wire logic [3:0] PHASE_TRIP_O,
	input wire logic GENERAL_ALARM_O,
	input wire logic GENERAL_TRIP_O,
	input wire logic BREAKER_TRIP_O,
	input wire logic PROT_ACTIVE_O,
	input wire logic TRIP_BLOCKED_O,
	input wire logic TRIP_EXT_BLOCKED_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	// Phase map of the previous cycle, as the outputs are registered
	function automatic logic [3:0] ph(input logic [NUM_ELEM-1:0] v, input logic [NUM_ELEM*4-1:0] p);
		ph = 4'h0;
		for (int i = 0; i < NUM_ELEM; i++)
			if (v[i]) ph = ph | p[4*i +: 4];
	endfunction
	property p_ph_alarm; PHASE_ALARM_O == ph(ELEM_ALARM_O, $past(ELEM_PHASE_I)); endproperty
	a_ph_alarm: assert property (p_ph_alarm) else $error("phase alarm collection wrong");
	property p_ph_trip; PHASE_TRIP_O == ph(ELEM_TRIP_O, $past(ELEM_PHASE_I)); endproperty
	a_ph_trip: assert property (p_ph_trip) else $error("phase trip collection wrong");
	property p_gen_trip; GENERAL_TRIP_O == (|ELEM_TRIP_O); endproperty
	a_gen_trip: assert property (p_gen_trip) else $error("general trip wrong");
	property p_gen_alarm; GENERAL_ALARM_O |-> (|ELEM_ALARM_O); endproperty
	a_gen_alarm: assert property (p_gen_alarm) else $error("general alarm without cause");
	property p_breaker; BREAKER_TRIP_O |-> GENERAL_TRIP_O; endproperty
	a_breaker: assert property (p_breaker) else $error("breaker trip without trip");
	property p_off; !PROT_ACTIVE_O |-> ELEM_ALARM_O == '0 && ELEM_TRIP_O == '0; endproperty
	a_off: assert property (p_off) else $error("output while protection inactive");
	property p_trip_sup; TRIP_BLOCKED_O || TRIP_EXT_BLOCKED_O |-> ELEM_TRIP_O == '0; endproperty
	a_trip_sup: assert property (p_trip_sup) else $error("trip while suppressed");
	property p_trip_src; (ELEM_TRIP_O & ~$past(ELEM_TRIP_I)) == '0; endproperty
	a_trip_src: assert property (p_trip_src) else $error("trip without element trip");
	property p_alarm_src; (ELEM_ALARM_O & ~$past(ELEM_ALARM_I)) == '0; endproperty
	a_alarm_src: assert property (p_alarm_src) else $error("alarm without element alarm");
endmodule
bind ppf_frame ppf_frame_monitor u_mon (.CORE_CLK_I, .RSTN_I, .ELEM_ALARM_I, .ELEM_TRIP_I,
	.ELEM_PHASE_I, .ELEM_ALARM_O, .ELEM_TRIP_O, .PHASE_ALARM_O, .PHASE_TRIP_O, .GENERAL_ALARM_O,
	.GENERAL_TRIP_O, .BREAKER_TRIP_O, .PROT_ACTIVE_O, .TRIP_BLOCKED_O, .TRIP_EXT_BLOCKED_O);

/* ppf_elem_model.sv */
// Model of the protection elements that feed the frame
`timescale 1ns/1ps
module ppf_elem_model
	import ppf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [NUM_ELEM-1:0] pick_i,
	input wire logic [NUM_ELEM-1:0] decide_i,
	output logic [NUM_ELEM-1:0] alarm_o,
	output logic [NUM_ELEM-1:0] trip_o
);
	// An element can only decide a trip while it has picked up
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alarm_o <= '0;
			trip_o <= '0;
		end else begin
			alarm_o <= pick_i;
			trip_o <= pick_i & decide_i;
		end
	end
endmodule

/* testbench.sv */
// Randomised self-checking bench of the protection frame
`timescale 1ns/1ps
module testbench;
	import ppf_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, fok = 1'b1, fev = 1'b0, gev = 1'b0;
	logic [7:0] aw_a = 8'h00, ar_a = 8'h00, rev = 8'h00, pick = 8'h00, dec = 8'h00;
	logic [7:0] alarm, trip, ea, et, en;
	logic [31:0] w_d = 32'h0, phase = 32'h0, rd, rdata, r, k, q;
	logic [15:0] src = 16'h0, s, x;
	logic [3:0] pa, pt, ctl;
	logic [2:0] gis;
	logic [1:0] bresp, rresp, resp;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, ga, gt, bt, act, xb, tb, txb, fc;
	int fails = 0;
	int cmp_count = 0;
	int seed = 94068;
	localparam logic [7:0] DA [6] = '{ADDR_GLOBAL_CTRL, ADDR_ELEM_ENABLE, ADDR_ELEM_EXT_PERMIT,
		ADDR_ELEM_TRIP_BLOCK, ADDR_ELEM_TRIP_PERMIT, ADDR_GLOBAL_SEL};
	localparam logic [31:0] DV [6] = '{32'(GC_RESET), 32'(ELEM_RESET_ON), 32'h0, 32'h0, 32'h0,
		{8'h00, 3'h0, SEL_NONE, 3'h0, SEL_NONE, 3'h0, SEL_NONE}};
	always #4 clk = ~clk;
	ppf_elem_model pm (.clk_i(clk), .rst_n_i(rst_n), .pick_i(pick), .decide_i(dec),
		.alarm_o(alarm), .trip_o(trip));
	ppf_frame uut (.CORE_CLK_I(clk), .RSTN_I(rst_n), .BLOCK_SRC_I(src), .FREQ_OK_I(fok),
		.REV_INTERLOCK_I(rev), .ELEM_ALARM_I(alarm), .ELEM_TRIP_I(trip), .ELEM_PHASE_I(phase),
		.FAULT_EVENT_I(fev), .GRID_FAULT_EVENT_I(gev), .ELEM_ALARM_O(ea), .ELEM_TRIP_O(et),
		.PHASE_ALARM_O(pa), .PHASE_TRIP_O(pt), .GENERAL_ALARM_O(ga), .GENERAL_TRIP_O(gt),
		.BREAKER_TRIP_O(bt), .PROT_ACTIVE_O(act), .EXT_BLOCKED_O(xb), .TRIP_BLOCKED_O(tb),
		.TRIP_EXT_BLOCKED_O(txb), .GLOBAL_INPUT_STATE_O(gis), .FAULT_CLEAR_O(fc),
		.S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_d),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v),
		.S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(r_v),
		.S_AXI_RREADY(r_r));
	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		forever begin
			@(posedge clk);
			if (aw_v && aw_rdy)
				aw_v <= 1'b0;
			if (w_v && w_rdy)
				w_v <= 1'b0;
			if (b_v) begin
				resp = bresp;
				break;
			end
		end
		b_r <= 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		forever begin
			@(posedge clk);
			if (ar_v && ar_rdy)
				ar_v <= 1'b0;
			if (r_v) begin
				rd = rdata;
				resp = rresp;
				break;
			end
		end
		r_r <= 1'b0;
	endtask
	// Source selects: assigned (A=3, B=7, trip=9, element i block i, trip 8+i) or none
	task sels(input logic a);
		wr(ADDR_GLOBAL_SEL, a ? 32'h0009_0703 : 32'h001F_1F1F);
		for (int i = 0; i < NUM_ELEM; i++)
			wr(ADDR_ELEM_SEL_BASE + 8'(4 * i), a ? 32'(((8 + i) << ES_TRIP) | i) : 32'h1F1F);
	endtask
	function automatic logic [3:0] phx(input logic [7:0] v);
		phx = 4'h0;
		for (int i = 0; i < 8; i++)
			if (v[i]) phx = phx | phase[4*i +: 4];
	endfunction
	// Expected gated {alarms, trips} from the settings and the effective sources
	function automatic logic [15:0] gate(input logic [15:0] s);
		logic [7:0] eb, xa, xt;
		eb = (k[31:24] & s[7:0]) | (fok ? 8'h00 : q[15:8]) | (q[23:16] & rev);
		xa = alarm & en & ~eb;
		xt = trip & en & ~eb & ~k[7:0] & ~(k[15:8] & s[15:8]);
		if (!ctl[0] || (ctl[1] && (s[3] || s[7])))
			xa = 8'h00;
		if (!ctl[0] || (ctl[1] && (s[3] || s[7])) || ctl[2] || (ctl[3] && s[9]))
			xt = 8'h00;
		gate = {xa, xt};
	endfunction
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdr(DA[i]);
			chk(rd, DV[i], "reset value");
		end
		rdr(8'h30);
		chk(32'(resp), 32'(RESP_SLVERR), "unmapped read");
		wr(ADDR_STATUS, 32'h0);
		chk(32'(resp), 32'(RESP_SLVERR), "read-only write");
		$display("test defaults done");
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			fev <= 1'b1;
			gev <= (i < 2);
			@(posedge clk);
			fev <= 1'b0;
			gev <= 1'b0;
		end
		rdr(ADDR_FAULT_CNT);
		chk(rd, 32'h0002_0003, "fault counts");
		wr(ADDR_GLOBAL_CTRL, 32'h11);
		repeat (2) @(posedge clk);
		chk(32'(fc), 32'h1, "clear command");
		rdr(ADDR_FAULT_CNT);
		chk(rd, 32'h0, "cleared counts");
		$display("test counters done");
		for (int n = 0; n < 80; n++) begin
			if (n % 40 == 0)
				sels(n > 0);
			r = $random(seed);
			k = $random(seed);
			q = $random(seed);
			ctl = {r[3:1], n % 4 != 0};
			en = r[11:4] | r[19:12];
			wr(ADDR_GLOBAL_CTRL, 32'(ctl));
			wr(ADDR_ELEM_ENABLE, 32'(en));
			wr(ADDR_ELEM_EXT_PERMIT, 32'(k[31:24]));
			wr(ADDR_ELEM_TRIP_BLOCK, 32'(k[7:0]));
			wr(ADDR_ELEM_TRIP_PERMIT, 32'(k[15:8]));
			wr(ADDR_CB_ASSIGN, 32'(k[23:16]));
			wr(ADDR_ELEM_CLASS, q & 32'h00FF_FFFF);
			@(posedge clk);
			src <= 16'($random(seed) & $random(seed));
			fok <= r[0];
			rev <= r[31:24];
			phase <= $random(seed);
			pick <= 8'($random(seed));
			dec <= 8'($random(seed));
			repeat (5) @(posedge clk);
			s = (n < 40) ? 16'h0 : src;
			x = gate(s);
			chk(32'(ea), 32'(x[15:8]), "element alarms");
			chk(32'(et), 32'(x[7:0]), "element trips");
			chk(32'(pa), 32'(phx(x[15:8])), "phase alarms");
			chk(32'(pt), 32'(phx(x[7:0])), "phase trips");
			chk(32'(ga), 32'(|(x[15:8] & ~q[7:0])), "general alarm");
			chk(32'(gt), 32'(|x[7:0]), "general trip");
			chk(32'(bt), 32'(|(x[7:0] & k[23:16])), "breaker trip");
			chk(32'(gis), 32'({s[9], s[7], s[3]}), "input states");
			chk(32'({xb, tb, txb}), 32'({ctl[1] & (s[3] | s[7]), ctl[2], ctl[3] & s[9]}), "status");
			chk(32'(act), 32'(ctl[0] & ~(ctl[1] & (s[3] | s[7]))), "protection active");
		end
		$display("test random gating done");
		stop_test;
	end
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		stop_test;
	end
endmodule
